// [hdl/lmem_pkg.sv]
package lmem_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int PTR_W = 21;
  localparam int IDX_W = 9;
  localparam int N_CPU = 2;
  localparam int N_DMA = 2;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] OFS_TX_BASE = 10'h0d0;
  localparam logic [ADDR_W-1:0] OFS_TX_FILL = 10'h0d4;
  localparam logic [ADDR_W-1:0] OFS_TX_DRAIN = 10'h0d8;
  localparam logic [ADDR_W-1:0] OFS_TX_ALLOC = 10'h0dc;
  localparam logic [ADDR_W-1:0] OFS_RXD_FILL = 10'h0e0;
  localparam logic [ADDR_W-1:0] OFS_RXD_DRAIN = 10'h0e4;
  localparam logic [ADDR_W-1:0] OFS_RXD_REF = 10'h0e8;
  localparam logic [ADDR_W-1:0] OFS_PRIO = 10'h0ec;
  localparam logic [ADDR_W-1:0] OFS_TXD_FILL = 10'h0f0;
  localparam logic [ADDR_W-1:0] OFS_TXD_DRAIN = 10'h0f4;
  localparam logic [ADDR_W-1:0] OFS_TXD_REF = 10'h0f8;

  // ----------------------------------------
  // pointer layout and memory geometry
  // ----------------------------------------
  localparam int PTR_LSB = 3;
  localparam int BASE_LSB = 12;
  localparam logic [PTR_W:0] DW_BYTES = 22'h000008;
  localparam logic [PTR_W:0] DW_ROUND = 22'h000007;
  localparam logic [PTR_W-1:0] WORD_BYTES = 21'h000004;
  localparam logic [PTR_W:0] LMEM_TOP = 22'h200000;
  localparam int RX_BLK_SHIFT = 7;
  localparam logic [7:0] SAT_MAX = 8'hff;
  localparam int DESC_SHIFT = 5;
  localparam logic [PTR_W-1:0] RING_BYTES = 21'h004000;
  localparam logic [IDX_W-1:0] IDX_ONE = 9'h001;

  // ----------------------------------------
  // priority register fields
  // ----------------------------------------
  localparam int F_RXBUF_LSB = 24;
  localparam int F_RXDESC_LSB = 16;
  localparam int F_FL_SETUP_LSB = 14;
  localparam int F_FL_OP_LSB = 10;
  localparam int F_FL_HOLD_LSB = 8;
  localparam int F_PRIO_B_LSB = 4;
  localparam int F_PRIO_A_LSB = 0;
  localparam int PRIO_WR_W = 16;
  localparam logic [3:0] PRIO_MAX = 4'hf;
  localparam logic [3:0] WAIT_ONE = 4'h1;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [PTR_W-1:0] PTR_RST = 21'h000000;
  localparam logic [IDX_W-1:0] IDX_RST = 9'h000;
  localparam logic [PRIO_WR_W-1:0] PRIO_RST = 16'h0000;
  localparam logic [3:0] WAIT_RST = 4'h0;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef struct packed {
    logic tx_drain_adv;
    logic rx_pkt_start;
    logic rx_pkt_done;
    logic tx_desc_sent;
  } hw_evt_s;

  typedef struct packed {
    logic [PTR_W-1:0] base;
    logic [PTR_W-1:0] fill;
    logic [PTR_W-1:0] drain;
  } rx_buf_s;

  typedef struct packed {
    logic [PTR_W-1:0] tx_base;
    logic tx_ready;
    logic [PTR_W-1:0] tx_fill;
    logic [PTR_W-1:0] tx_drain;
    logic [PTR_W-1:0] tx_next;
    logic [PTR_W-1:0] alloc_res;
    logic tx_pending;
    logic [IDX_W-1:0] rxd_fill;
    logic [IDX_W-1:0] rxd_drain;
    logic [IDX_W-1:0] rxd_ref;
    logic rx_active;
    logic rx_start_evt;
    logic rx_end_evt;
    logic [IDX_W-1:0] txd_fill;
    logic [IDX_W-1:0] txd_drain;
    logic [IDX_W-1:0] txd_ref;
    logic [PRIO_WR_W-1:0] prio;
    logic [N_CPU-1:0][3:0] wait_cnt;
    logic [N_CPU-1:0] cpu_force;
    logic [N_DMA-1:0] dma_reload;
    logic [DATA_W-1:0] rdata;
  } state_s;

endpackage : lmem_pkg

// [hdl/local_memory_ring_pointers.sv]
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
// How it works
// R1 - transmit start: 21 bits, 4k aligned
// R2 - transmit region ends before receive start
// R3 - dma reloads transmit start after last word
// R4 - software fills, hardware compares fill to drain
// R5 - hardware advances drain by two words
// R6 - allocator returns start address or zero
// R7 - allocation consumes length rounded to doubleword
// R8 - zero length only peeks next start
// R9 - receive descriptor fill advanced around packet
// R10 - descriptor rings stacked below transmit start
// R11 - software writes receive descriptor drain index
// R12 - receive reference compare gives start/end events
// R13 - processor waits at most 15 minus priority; at priority 15 the code still waits one cycle before force
// R14 - wait counter runs only while request pending
// R15 - all processor accesses share one counter
// R16 - firmware keeps priority low, rarely fifteen
// R17 - bits 31-24: free receive blocks, saturated
// R18 - bits 23-16: free receive descriptors, saturated
// R19 - flash setup, strobe, hold timing fields
// R20 - two processor priority fields, reset zero
// R21 - software advances transmit descriptor fill index
// R22 - hardware advances transmit descriptor drain index
// R23 - pointers doubleword aligned in bits 20-3
// R24 - index reads return full descriptor address
module local_memory_ring_pointers (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register port
  input wire lmem_pkg::reg_req_s reg_req,
  output logic [lmem_pkg::DATA_W-1:0] reg_rdata,
  // receive buffer state from the receive side
  input wire lmem_pkg::rx_buf_s rx_buf,
  // hardware progress pulses
  input wire lmem_pkg::hw_evt_s hw_evt,
  // dma address watch
  input wire logic [lmem_pkg::N_DMA-1:0][lmem_pkg::PTR_W-1:0] dma_addr,
  input wire logic [lmem_pkg::N_DMA-1:0] dma_access,
  output logic [lmem_pkg::N_DMA-1:0] dma_reload,
  output logic [lmem_pkg::PTR_W-1:0] tx_start_addr,
  output logic tx_ready,
  output logic tx_pending,
  // processor arbitration
  input wire logic [lmem_pkg::N_CPU-1:0] cpu_pending,
  input wire logic [lmem_pkg::N_CPU-1:0] cpu_done,
  output logic [lmem_pkg::N_CPU-1:0] cpu_force,
  // flash timing
  output logic [1:0] flash_setup,
  output logic [3:0] flash_strobe,
  output logic [1:0] flash_hold,
  // descriptor events
  output logic rx_start_evt,
  output logic rx_end_evt
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------

  // advance a pointer inside [start, limit) and wrap back to start
  function automatic logic [lmem_pkg::PTR_W-1:0] wrap_add(
    input logic [lmem_pkg::PTR_W-1:0] p,
    input logic [lmem_pkg::PTR_W:0] step,
    input logic [lmem_pkg::PTR_W-1:0] limit,
    input logic [lmem_pkg::PTR_W:0] size
  );
    logic [lmem_pkg::PTR_W:0] sum;
    sum = {1'b0, p} + step;

    if (sum >= {1'b0, limit}) begin
      sum = sum - size;
    end
    return sum[lmem_pkg::PTR_W-1:0];
  endfunction : wrap_add

  // full local address of a descriptor
  function automatic logic [lmem_pkg::PTR_W-1:0] desc_addr(
    input logic [lmem_pkg::PTR_W-1:0] base,
    input logic [lmem_pkg::IDX_W-1:0] idx
  );
    logic [lmem_pkg::PTR_W-1:0] ofs;
    ofs = lmem_pkg::PTR_W'({idx, {lmem_pkg::DESC_SHIFT{1'b0}}});

    return base + ofs;
  endfunction : desc_addr

  // ----------------------------------------
  // state
  // ----------------------------------------
  lmem_pkg::state_s st_ff;
  lmem_pkg::state_s nxt_st;

  // derived geometry and status
  logic [lmem_pkg::PTR_W-1:0] rxd_base;
  logic [lmem_pkg::PTR_W-1:0] txd_base;
  logic [lmem_pkg::PTR_W-1:0] tx_last;
  logic [lmem_pkg::PTR_W:0] tx_size;
  logic [lmem_pkg::PTR_W:0] tx_free;
  logic [lmem_pkg::PTR_W:0] tx_avail;

  // receive side status
  logic [lmem_pkg::PTR_W:0] rx_size;
  logic [lmem_pkg::PTR_W:0] rx_free;
  logic [lmem_pkg::PTR_W:0] rx_blocks;
  logic [lmem_pkg::IDX_W-1:0] rxd_free;
  logic [7:0] rx_blk_sat;
  logic [7:0] rxd_free_sat;
  logic [lmem_pkg::PTR_W:0] req_len;

  // write fields shared by several registers
  logic [lmem_pkg::IDX_W-1:0] wr_idx;
  logic [lmem_pkg::PTR_W-1:0] wr_ptr;
  assign wr_idx = reg_req.wdata[lmem_pkg::DESC_SHIFT +: lmem_pkg::IDX_W];
  // low and reserved bits drop on write [R23]
  assign wr_ptr = {reg_req.wdata[lmem_pkg::PTR_W-1:lmem_pkg::PTR_LSB],
    {lmem_pkg::PTR_LSB{1'b0}}}; // [R23]

  // descriptor rings hang below the transmit start, receive ring first [R10]
  assign rxd_base = st_ff.tx_base - lmem_pkg::RING_BYTES; // [R10]
  assign txd_base = rxd_base - lmem_pkg::RING_BYTES; // [R10]

  // transmit region runs from its start to one word below receive start [R2]
  assign tx_last = rx_buf.base - lmem_pkg::WORD_BYTES; // [R2]
  assign tx_size = {1'b0, rx_buf.base} - {1'b0, st_ff.tx_base}; // [R2]

  // free transmit space between the allocation point and the drain [R4]
  always_comb begin
    if (st_ff.tx_next < st_ff.tx_drain) begin
      tx_free = {1'b0, st_ff.tx_drain} - {1'b0, st_ff.tx_next};
    end else begin
      tx_free = tx_size - ({1'b0, st_ff.tx_next} - {1'b0, st_ff.tx_drain}); // [R4]
    end
    // one doubleword stays unused so that full never looks like empty
    if (tx_free > lmem_pkg::DW_BYTES) begin
      tx_avail = tx_free - lmem_pkg::DW_BYTES;
    end else begin
      tx_avail = '0;
    end
  end

  // receive buffer free space in 128 byte blocks [R17]
  assign rx_size = lmem_pkg::LMEM_TOP - {1'b0, rx_buf.base};
  always_comb begin
    if (rx_buf.fill < rx_buf.drain) begin
      rx_free = {1'b0, rx_buf.drain} - {1'b0, rx_buf.fill};
    end else begin
      rx_free = rx_size - ({1'b0, rx_buf.fill} - {1'b0, rx_buf.drain});
    end
    rx_blocks = rx_free >> lmem_pkg::RX_BLK_SHIFT;
    if (rx_blocks > {14'h0000, lmem_pkg::SAT_MAX}) begin
      rx_blk_sat = lmem_pkg::SAT_MAX; // [R17]
    end else begin
      rx_blk_sat = rx_blocks[7:0];
    end
  end

  // descriptors the receive side may still use, saturated [R18]
  assign rxd_free = st_ff.rxd_drain - st_ff.rxd_fill - lmem_pkg::IDX_ONE;
  always_comb begin
    if (rxd_free > {1'b0, lmem_pkg::SAT_MAX}) begin
      rxd_free_sat = lmem_pkg::SAT_MAX; // [R18]
    end else begin
      rxd_free_sat = rxd_free[7:0];
    end
  end

  // requested packet length rounded up to a doubleword [R7]
  assign req_len = ({1'b0, reg_req.wdata[lmem_pkg::PTR_W-1:0]} + lmem_pkg::DW_ROUND)
    & ~lmem_pkg::DW_ROUND; // [R7]

  // ----------------------------------------
  // next state
  // ----------------------------------------

  // hardware updates first, then a software write on top of them
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rx_start_evt = 1'b0;
    nxt_st.rx_end_evt = 1'b0;

    // drain follows the network side two words at a time [R5]
    if (hw_evt.tx_drain_adv && (st_ff.tx_drain != st_ff.tx_fill)) begin
      nxt_st.tx_drain = wrap_add(st_ff.tx_drain, lmem_pkg::DW_BYTES,
        rx_buf.base, tx_size); // [R5]
    end

    // receive descriptor fill: opened at packet start, advanced at end [R9]
    if (hw_evt.rx_pkt_start) begin
      nxt_st.rx_active = 1'b1; // [R9]
      nxt_st.rx_start_evt = (st_ff.rxd_fill == st_ff.rxd_ref); // [R12]
    end
    if (hw_evt.rx_pkt_done && st_ff.rx_active) begin
      nxt_st.rx_active = hw_evt.rx_pkt_start;
      nxt_st.rxd_fill = st_ff.rxd_fill + lmem_pkg::IDX_ONE; // [R9]
      nxt_st.rx_end_evt = (st_ff.rxd_fill == st_ff.rxd_ref); // [R12]
    end

    // transmit descriptor drain after each sent descriptor [R22]
    if (hw_evt.tx_desc_sent && (st_ff.txd_drain != st_ff.txd_fill)) begin
      nxt_st.txd_drain = st_ff.txd_drain + lmem_pkg::IDX_ONE; // [R22]
    end

    // dma address at the last transmit word reloads after its access [R3]
    for (int d = 0; d < lmem_pkg::N_DMA; d++) begin
      nxt_st.dma_reload[d] = dma_access[d] && (dma_addr[d] == tx_last); // [R3]
    end

    // processor wait counters, one per processor, shared by all accesses
    for (int c = 0; c < lmem_pkg::N_CPU; c++) begin
      logic [3:0] prio_c;
      logic [3:0] limit_c;
      logic [4:0] reach_c;
      prio_c = st_ff.prio[c*4 +: 4];
      limit_c = lmem_pkg::PRIO_MAX - prio_c; // [R13]
      reach_c = {1'b0, st_ff.wait_cnt[c]} + {1'b0, lmem_pkg::WAIT_ONE};
      if (cpu_done[c] || !cpu_pending[c]) begin
        nxt_st.wait_cnt[c] = lmem_pkg::WAIT_RST; // [R14]
        nxt_st.cpu_force[c] = 1'b0;
      end else begin
        // fetches and load/store both arrive as cpu_pending [R15]
        if (st_ff.wait_cnt[c] != lmem_pkg::PRIO_MAX) begin
          nxt_st.wait_cnt[c] = st_ff.wait_cnt[c] + lmem_pkg::WAIT_ONE; // [R14]
        end
        // one bit wider, so a full count cannot wrap and drop force
        nxt_st.cpu_force[c] = (reach_c >= {1'b0, limit_c}); // [R13]
      end
    end

    // software writes
    if (reg_req.wr) begin
      case (reg_req.addr)
        lmem_pkg::OFS_TX_BASE: begin
          // a new start also restarts every pointer of the region
          nxt_st.tx_base = {reg_req.wdata[lmem_pkg::PTR_W-1:lmem_pkg::BASE_LSB],
            {lmem_pkg::BASE_LSB{1'b0}}}; // [R1]
          nxt_st.tx_fill = nxt_st.tx_base;
          nxt_st.tx_drain = nxt_st.tx_base;
          nxt_st.tx_next = nxt_st.tx_base;
          nxt_st.tx_ready = 1'b1; // [R1]
        end

        lmem_pkg::OFS_TX_FILL: begin
          nxt_st.tx_fill = wr_ptr; // [R4] [R23]
        end

        lmem_pkg::OFS_TX_DRAIN: begin
          nxt_st.tx_drain = wr_ptr; // [R5] [R23]
        end

        lmem_pkg::OFS_TX_ALLOC: begin
          if (reg_req.wdata[lmem_pkg::PTR_W-1:0] == '0) begin
            nxt_st.alloc_res = st_ff.tx_next; // [R8]
          end else if (req_len <= tx_avail) begin
            nxt_st.alloc_res = st_ff.tx_next; // [R6]
            nxt_st.tx_next = wrap_add(st_ff.tx_next, req_len, rx_buf.base, tx_size); // [R7]
          end else begin
            nxt_st.alloc_res = lmem_pkg::PTR_RST; // [R6]
          end
        end

        lmem_pkg::OFS_RXD_FILL: begin
          nxt_st.rxd_fill = wr_idx;
        end

        lmem_pkg::OFS_RXD_DRAIN: begin
          nxt_st.rxd_drain = wr_idx; // [R11]
        end

        lmem_pkg::OFS_RXD_REF: begin
          nxt_st.rxd_ref = wr_idx; // [R12]
        end

        lmem_pkg::OFS_PRIO: begin
          nxt_st.prio = reg_req.wdata[lmem_pkg::PRIO_WR_W-1:0]; // [R19] [R20]
        end

        lmem_pkg::OFS_TXD_FILL: begin
          nxt_st.txd_fill = wr_idx; // [R21]
        end

        lmem_pkg::OFS_TXD_DRAIN: begin
          nxt_st.txd_drain = wr_idx;
        end

        lmem_pkg::OFS_TXD_REF: begin
          nxt_st.txd_ref = wr_idx;
        end

        default: begin
        end
      endcase
    end

    // fill pointer is software's alone; hardware only compares [R4]
    nxt_st.tx_pending = (nxt_st.tx_fill != nxt_st.tx_drain); // [R4]

    // read data stand for exactly the cycle after the strobe
    nxt_st.rdata = '0;
    if (reg_req.rd) begin
      case (reg_req.addr)
        lmem_pkg::OFS_TX_BASE: nxt_st.rdata = {11'h000, st_ff.tx_base}; // [R1]
        lmem_pkg::OFS_TX_FILL: nxt_st.rdata = {11'h000, st_ff.tx_fill}; // [R23]
        lmem_pkg::OFS_TX_DRAIN: nxt_st.rdata = {11'h000, st_ff.tx_drain}; // [R23]
        lmem_pkg::OFS_TX_ALLOC: nxt_st.rdata = {11'h000, st_ff.alloc_res}; // [R6]

        lmem_pkg::OFS_RXD_FILL: begin
          nxt_st.rdata = {11'h000, desc_addr(rxd_base, st_ff.rxd_fill)}; // [R9] [R24]
        end

        lmem_pkg::OFS_RXD_DRAIN: begin
          nxt_st.rdata = {11'h000, desc_addr(rxd_base, st_ff.rxd_drain)}; // [R11] [R24]
        end

        lmem_pkg::OFS_RXD_REF: begin
          nxt_st.rdata = {11'h000, desc_addr(rxd_base, st_ff.rxd_ref)}; // [R12] [R24]
        end

        lmem_pkg::OFS_PRIO: begin
          nxt_st.rdata = {rx_blk_sat, rxd_free_sat, st_ff.prio}; // [R17] [R18]
        end

        lmem_pkg::OFS_TXD_FILL: begin
          nxt_st.rdata = {11'h000, desc_addr(txd_base, st_ff.txd_fill)}; // [R21] [R24]
        end

        lmem_pkg::OFS_TXD_DRAIN: begin
          nxt_st.rdata = {11'h000, desc_addr(txd_base, st_ff.txd_drain)}; // [R22] [R24]
        end

        lmem_pkg::OFS_TXD_REF: begin
          nxt_st.rdata = {11'h000, desc_addr(txd_base, st_ff.txd_ref)}; // [R24]
        end
        default: nxt_st.rdata = '0;
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------

  // one flop bank for the whole block; priorities come up at zero
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_ff <= '0;
      st_ff.tx_base <= lmem_pkg::PTR_RST;
      st_ff.tx_fill <= lmem_pkg::PTR_RST;
      st_ff.tx_drain <= lmem_pkg::PTR_RST;
      st_ff.tx_next <= lmem_pkg::PTR_RST;
      st_ff.rxd_fill <= lmem_pkg::IDX_RST;
      st_ff.rxd_drain <= lmem_pkg::IDX_RST;
      st_ff.txd_fill <= lmem_pkg::IDX_RST;
      st_ff.txd_drain <= lmem_pkg::IDX_RST;
      st_ff.prio <= lmem_pkg::PRIO_RST; // [R20]
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------
  assign reg_rdata = st_ff.rdata;
  assign dma_reload = st_ff.dma_reload;
  assign tx_start_addr = st_ff.tx_base;
  assign tx_ready = st_ff.tx_ready;
  assign tx_pending = st_ff.tx_pending;

  assign cpu_force = st_ff.cpu_force;

  assign flash_setup = st_ff.prio[lmem_pkg::F_FL_SETUP_LSB +: 2]; // [R19]
  assign flash_strobe = st_ff.prio[lmem_pkg::F_FL_OP_LSB +: 4]; // [R19]
  assign flash_hold = st_ff.prio[lmem_pkg::F_FL_HOLD_LSB +: 2]; // [R19]

  assign rx_start_evt = st_ff.rx_start_evt;
  assign rx_end_evt = st_ff.rx_end_evt;

endmodule : local_memory_ring_pointers

// [sim/local_memory_ring_pointers_checker.sv]
`timescale 1ns/10ps
module local_memory_ring_pointers_checker (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register port
  input wire lmem_pkg::reg_req_s reg_req,
  input wire logic [lmem_pkg::DATA_W-1:0] reg_rdata,
  // receive side
  input wire lmem_pkg::rx_buf_s rx_buf,
  input wire lmem_pkg::hw_evt_s hw_evt,
  // dma watch
  input wire logic [lmem_pkg::N_DMA-1:0][lmem_pkg::PTR_W-1:0] dma_addr,
  input wire logic [lmem_pkg::N_DMA-1:0] dma_access,
  input wire logic [lmem_pkg::N_DMA-1:0] dma_reload,
  input wire logic [lmem_pkg::PTR_W-1:0] tx_start_addr,
  input wire logic tx_ready,
  input wire logic tx_pending,
  // arbitration
  input wire logic [lmem_pkg::N_CPU-1:0] cpu_pending,
  input wire logic [lmem_pkg::N_CPU-1:0] cpu_done,
  input wire logic [lmem_pkg::N_CPU-1:0] cpu_force,
  // flash timing and events
  input wire logic [1:0] flash_setup,
  input wire logic [3:0] flash_strobe,
  input wire logic [1:0] flash_hold,
  input wire logic rx_start_evt,
  input wire logic rx_end_evt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // ----------------------------------------
  // helper: wait count and priority shadow
  // ----------------------------------------
  logic [1:0][3:0] cnt_ff;
  logic [7:0] prio_ff;
  // shadow follows writes only, so a decode slip shows
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_ff <= '0;
      prio_ff <= '0;
    end else begin
      if (reg_req.wr && reg_req.addr == lmem_pkg::OFS_PRIO) begin
        prio_ff <= reg_req.wdata[7:0];
      end
      for (int c = 0; c < 2; c++) begin
        if (cpu_pending[c] && !cpu_done[c]) begin
          cnt_ff[c] <= (cnt_ff[c] == 4'hf) ? 4'hf : cnt_ff[c] + 4'h1;
        end else begin
          cnt_ff[c] <= 4'h0;
        end
      end
    end
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  property force_p(int c);
    (cnt_ff[c] != 4'h0 && cnt_ff[c] >= 4'hf - prio_ff[c*4 +: 4]) |-> cpu_force[c];
  endproperty

  property reload_p(int d);
    (dma_access[d] && dma_addr[d] == rx_buf.base - lmem_pkg::WORD_BYTES) |=> dma_reload[d];
  endproperty

  reload_zero_a: assert property (reload_p(0))
    else $error("dma 0 no reload");
  reload_one_a: assert property (reload_p(1))
    else $error("dma 1 no reload");
  reload_cause_a: assert property ((dma_reload & ~$past(dma_access)) == 2'b00)
    else $error("stray reload");
  flash_map_a: assert property (
    (reg_req.wr && reg_req.addr == lmem_pkg::OFS_PRIO) |=>
    {flash_setup, flash_strobe, flash_hold} == $past(reg_req.wdata[15:8]))
    else $error("flash fields");
  tx_base_a: assert property (
    (reg_req.wr && reg_req.addr == lmem_pkg::OFS_TX_BASE) |=>
    tx_ready && tx_start_addr == {$past(reg_req.wdata[20:12]), 12'h000})
    else $error("start not taken");
  force_a_a: assert property (force_p(0))
    else $error("cpu a overwaited");
  force_b_a: assert property (force_p(1))
    else $error("cpu b overwaited");
  idle_force_a: assert property (!cpu_pending[0] [*2] |-> !cpu_force[0])
    else $error("idle force");
  rx_start_a: assert property (rx_start_evt |-> $past(hw_evt.rx_pkt_start))
    else $error("stray start event");
  rx_end_a: assert property (rx_end_evt |-> $past(hw_evt.rx_pkt_done))
    else $error("stray end event");

  // main scenarios reached
  reload_c: cover property (dma_reload[0]);
  force_c: cover property (cpu_force[1]);
  rx_end_c: cover property (rx_end_evt);
endmodule : local_memory_ring_pointers_checker

bind local_memory_ring_pointers local_memory_ring_pointers_checker chk (
  .clk(clk), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .rx_buf(rx_buf), .hw_evt(hw_evt), .dma_addr(dma_addr), .dma_access(dma_access),
  .dma_reload(dma_reload), .tx_start_addr(tx_start_addr), .tx_ready(tx_ready),
  .tx_pending(tx_pending), .cpu_pending(cpu_pending), .cpu_done(cpu_done),
  .cpu_force(cpu_force), .flash_setup(flash_setup), .flash_strobe(flash_strobe),
  .flash_hold(flash_hold), .rx_start_evt(rx_start_evt), .rx_end_evt(rx_end_evt));

// [sim/local_memory_ring_pointers_bench.sv]
`timescale 1ns/10ps
module local_memory_ring_pointers_bench;
  logic clk;
  logic reset_n;
  lmem_pkg::reg_req_s reg_req;
  logic [31:0] reg_rdata;
  lmem_pkg::rx_buf_s rx_buf;
  lmem_pkg::hw_evt_s hw_evt;
  logic [1:0][20:0] dma_addr;
  logic [1:0] dma_access, dma_reload, cpu_pending, cpu_done, cpu_force;
  logic [20:0] tx_start_addr;
  logic tx_ready, tx_pending, rx_start_evt, rx_end_evt;
  logic [1:0] flash_setup, flash_hold;
  logic [3:0] flash_strobe;
  int fail_count, checks, seed, n;
  logic [31:0] rd_v, len, v, nxt;
  logic [3:0] ev;
  // 64k transmit below receive at 0e0000, rings below it
  logic [31:0] tb = 32'h000d0000;
  logic [31:0] rxb = 32'h000e0000;
  logic [31:0] rxr = 32'h000cc000;
  logic [31:0] txr = 32'h000c8000;
  logic [9:0] ofs [4] = '{10'h0e4, 10'h0e8, 10'h0f0, 10'h0f8};

  local_memory_ring_pointers dut (.clk(clk), .reset_n(reset_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .rx_buf(rx_buf), .hw_evt(hw_evt), .dma_addr(dma_addr),
    .dma_access(dma_access), .dma_reload(dma_reload), .tx_start_addr(tx_start_addr),
    .tx_ready(tx_ready), .tx_pending(tx_pending), .cpu_pending(cpu_pending),
    .cpu_done(cpu_done), .cpu_force(cpu_force), .flash_setup(flash_setup),
    .flash_strobe(flash_strobe), .flash_hold(flash_hold), .rx_start_evt(rx_start_evt),
    .rx_end_evt(rx_end_evt));

  // ----------------------------------------
  // tasks and models
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // a spare edge keeps each strobe single
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    reg_req.addr <= a;
    reg_req.wdata <= d;
    reg_req.wr <= 1'b1;
    @(posedge clk);
    reg_req.wr <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [9:0] a);
    reg_req.addr <= a;
    reg_req.rd <= 1'b1;
    @(posedge clk);
    reg_req.rd <= 1'b0;
    #1 rd_v = reg_rdata;
    @(posedge clk);
  endtask : rd

  // one-cycle pulse; answers caught a cycle later
  task automatic pulse(input logic [3:0] h, input logic [1:0] acc);
    hw_evt <= h;
    dma_access <= acc;
    @(posedge clk);
    hw_evt <= 4'h0;
    dma_access <= 2'b00;
    #1 ev = {rx_start_evt, rx_end_evt, dma_reload};
    @(posedge clk);
  endtask : pulse

  // allocator model: drain at the start, 8 bytes kept spare
  function automatic logic [31:0] alloc_exp(input logic [31:0] l);
    logic [31:0] r8, fr, res;
    r8 = (l + 32'h7) & ~32'h7;
    fr = (tb > nxt) ? tb - nxt : rxb - nxt;
    fr = fr - 32'h8;
    res = 32'h0;
    if (l == 32'h0) begin
      res = nxt;
    end else if (r8 <= fr) begin
      res = nxt;
      nxt = nxt + r8;
      if (nxt >= rxb) begin
        nxt = nxt - (rxb - tb);
      end
    end
    return res;
  endfunction : alloc_exp

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------
  // clock and sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    seed = 32'h0464;
    reset_n = 1'b0;
    reg_req = '0;
    rx_buf = {rxb[20:0], rxb[20:0], rxb[20:0]};
    hw_evt = 4'h0;
    dma_addr = '0;
    dma_access = 2'b00;
    cpu_pending = 2'b00;
    cpu_done = 2'b00;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd(lmem_pkg::OFS_PRIO);
    check(rd_v[23:0], 32'h00ff0000);
    check(tx_ready, 1'b0);
    // only the 4k-aligned part of the start is kept
    wr(lmem_pkg::OFS_TX_BASE, 32'hffed07ff);
    check(tx_start_addr, tb);
    check(tx_ready, 1'b1);
    rd(lmem_pkg::OFS_TX_BASE);
    check(rd_v, tb);
    wr(lmem_pkg::OFS_TX_FILL, 32'hffe00007 | (tb + 32'h40));
    rd(lmem_pkg::OFS_TX_FILL);
    check(rd_v, tb + 32'h40);
    check(tx_pending, 1'b1);
    repeat (9) pulse(4'h8, 2'b00);
    rd(lmem_pkg::OFS_TX_DRAIN);
    check(rd_v, tb + 32'h40);
    check(tx_pending, 1'b0);
    wr(10'h0fc, 32'hffffffff);
    rd(10'h0fc);
    check(rd_v, 32'h0);
    $display("tx pointers done");
    // allocator corners, then random lengths
    wr(lmem_pkg::OFS_TX_BASE, tb);
    nxt = tb;
    for (int i = 0; i < 24; i++) begin
      len = (i == 1) ? 32'hd : (i == 3) ? 32'h10000 : (i < 4) ? 32'h0 : $random(seed) & 32'h1fff;
      wr(lmem_pkg::OFS_TX_ALLOC, len);
      rd(lmem_pkg::OFS_TX_ALLOC);
      check(rd_v, alloc_exp(len));
    end
    $display("allocator done");
    for (int c = 0; c < 2; c++) begin
      dma_addr[c] <= 21'h0dfffc;
      pulse(4'h0, 2'b01 << c);
      check(ev[1:0], 2'b01 << c);
      dma_addr[c] <= 21'h0dfff8;
      pulse(4'h0, 2'b01 << c);
      check(ev[1:0], 2'b00);
    end
    $display("dma reload done");
    // rx descriptor events vs reference
    rd(lmem_pkg::OFS_RXD_FILL);
    check(rd_v, rxr);
    wr(lmem_pkg::OFS_RXD_REF, 32'h0);
    pulse(4'h4, 2'b00);
    check(ev[3], 1'b1);
    pulse(4'h2, 2'b00);
    check(ev[2], 1'b1);
    rd(lmem_pkg::OFS_RXD_FILL);
    check(rd_v, rxr + 32'h20);
    pulse(4'h4, 2'b00);
    check(ev[3], 1'b0);
    pulse(4'h2, 2'b00);
    check(ev[2], 1'b0);
    for (int k = 0; k < 4; k++) begin
      n = $random(seed) & 511;
      wr(ofs[k], ($random(seed) & ~32'h3fe0) | (n << 5));
      rd(ofs[k]);
      check(rd_v, ((k < 2) ? rxr : txr) + n * 32);
    end
    wr(lmem_pkg::OFS_TXD_FILL, 32'h3 << 5);
    repeat (2) pulse(4'h1, 2'b00);
    rd(lmem_pkg::OFS_TXD_DRAIN);
    check(rd_v, txr + 32'h40);
    repeat (2) pulse(4'h1, 2'b00);
    rd(lmem_pkg::OFS_TXD_DRAIN);
    check(rd_v, txr + 32'h60);
    $display("descriptors done");
    // status saturation; rx fill index is 2
    rx_buf.drain <= rxb[20:0] + 21'h100000;
    for (int d = 257; d < 260; d++) begin
      v = $random(seed) & 32'hffff;
      wr(lmem_pkg::OFS_PRIO, v);
      wr(lmem_pkg::OFS_RXD_DRAIN, d << 5);
      rd(lmem_pkg::OFS_PRIO);
      check(rd_v, {8'hff, (d > 258) ? 8'hff : 8'(d - 3), v[15:0]});
      check({flash_setup, flash_strobe, flash_hold}, v[15:8]);
    end
    $display("status done");
    // wait bound, top priority as a corner
    for (int p = 0; p < 16; p += 5) begin
      wr(lmem_pkg::OFS_PRIO, {24'h0, 4'(p), 4'(p)});
      for (int c = 0; c < 2; c++) begin
        cpu_pending[c] <= 1'b1;
        n = 0;
        do begin
          @(posedge clk);
          #1 n++;
        end while (cpu_force[c] !== 1'b1 && n < 20);
        check(n, (p == 15) ? 1 : 15 - p);
        @(posedge clk);
        cpu_done[c] <= 1'b1;
        cpu_pending[c] <= 1'b0;
        @(posedge clk);
        cpu_done[c] <= 1'b0;
        @(posedge clk);
        #1 check(cpu_force[c], 1'b0);
      end
    end
    $display("arbitration done");
    test_done();
  end
endmodule : local_memory_ring_pointers_bench
